// File: core/smim_defines.vh
// constants for the station mode and input map block
// assumes word-addressed buffer memory with 16-bit data
`ifndef SMIM_DEFINES_VH
`define SMIM_DEFINES_VH

// buffer memory word offsets
`define SMIM_OFS_ACTIVE_MODE 15'h08CE
`define SMIM_OFS_REQ_CODE 15'h08CF
`define SMIM_OFS_OUTCOME 15'h08D0
`define SMIM_OFS_OWN_ADDR 15'h08D1
`define SMIM_OFS_TEST_STATE 15'h08D2
`define SMIM_OFS_STORED_MODE 15'h08D3
`define SMIM_OFS_WIN_FIRST 15'h1800
`define SMIM_OFS_WIN_LAST 15'h27FF
`define SMIM_OFS_LOCAL_ERR 15'h5A1F

// mode codes reported and requested
`define SMIM_CODE_PARAM 16'h0001
`define SMIM_CODE_DIAG 16'h0002
`define SMIM_CODE_COMM 16'h0003
`define SMIM_CODE_INIT 16'h0009
`define SMIM_CODE_PARAM_NV 16'h0101
`define SMIM_CODE_COMM_NV 16'h0103
`define SMIM_CODE_ERASE 16'hFFFF
`define SMIM_CODE_NONE 16'hFFFF
`define SMIM_REQ_GUARD 16'hFFFE

// outcome codes
`define SMIM_OUT_OK 16'hA300
`define SMIM_OUT_GUARD 16'hE300
`define SMIM_OUT_BAD_CODE 16'hE301
`define SMIM_OUT_RESET 16'h0000

// local station values
`define SMIM_ERR_NONE 16'h0000
`define SMIM_ADDR_UNSET 16'hFFFF
`define SMIM_ADDR_MAX 7'h7D

// nonvolatile mode image encoding
`define SMIM_NV_NONE 2'h0
`define SMIM_NV_PARAM 2'h1
`define SMIM_NV_COMM 2'h2

// input layout limits
`define SMIM_SLAVES 125
`define SMIM_LAST_SLAVE 7'h7C
`define SMIM_MAX_LEN 8'hF4
`define SMIM_WIN_WORDS 13'h1000

`endif

// File: core/smim_station_regs.v
// station mode registers and cyclic input window of a fieldbus master
// assumes all inputs synchronous to ref_clk and a single clock domain
//
// Notes on behaviour
// - error register zero when healthy, else code
// - error code sticks until diag clear request
// - active mode codes 1, 2, 3, 9
// - report 0101/0103 when mode matches stored
// - stored mode 0101, 0103 or all-ones
// - own address 0..125, all-ones if unset
// - offline test status shows test state
// - request register resets to guard FFFE
// - guard value request gives E300, no change
// - codes 1,2,3,9 select the four modes
// - 0101/0103 switch and store mode
// - all-ones selects parameter mode, erases store
// - outcome A300 on success, error otherwise
// - slave data ordered by ascending bus address
// - config change recomputes slave region positions
// - failed exchange keeps last good data
// - window written only in communication mode
// - per slave up to 244, total 8192 bytes
// - odd length zero upper byte, next word
// - fixed length slaves ignore configured length
`timescale 1ns/1ps
`include "smim_defines.vh"

module smim_station_regs (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // buffer memory port
  input wire [14:0] bm_addr,
  input wire bm_rd,
  input wire bm_wr,
  input wire [15:0] bm_wdata,
  output reg [15:0] bm_rdata,
  output reg bm_rvalid,
  // request signals from the controller
  input wire mode_change_req,
  input wire diag_clear_request,
  output reg mode_change_done,
  // nonvolatile mode image, caught after reset
  input wire [1:0] nv_mode_in,
  output reg [1:0] nv_mode_out,
  // local station status
  input wire fault_valid,
  input wire [15:0] fault_code,
  input wire [6:0] node_addr,
  input wire params_set,
  input wire [15:0] test_status,
  // slave configuration
  input wire cfg_wr,
  input wire [6:0] cfg_slave,
  input wire [7:0] cfg_len,
  input wire cfg_fixed,
  input wire [7:0] cfg_fixed_len,
  // slave input byte stream
  input wire slv_valid,
  output wire slv_ready,
  input wire [6:0] slv_index,
  input wire [7:0] slv_byte,
  input wire slv_last,
  input wire slv_ok,
  // mode indication
  output wire comm_mode
);

  // one-hot operating modes
  localparam [3:0] ST_PARAM = 4'b0001;
  localparam [3:0] ST_DIAG = 4'b0010;
  localparam [3:0] ST_COMM = 4'b0100;
  localparam [3:0] ST_INIT = 4'b1000;

  integer i;
  reg [3:0] mode_reg; // active mode
  reg [1:0] stored_reg; // nonvolatile image
  reg boot_reg; // image not yet loaded
  reg [15:0] req_code_reg; // mode change request code
  reg [15:0] outcome_reg; // mode change result
  reg req_d_reg; // request delayed for edge
  reg [15:0] err_reg; // local error code
  reg [15:0] own_addr_reg; // displayed bus address
  reg [15:0] test_reg; // offline test status
  reg [15:0] active_code; // decoded mode code
  reg [15:0] stored_code; // decoded stored mode
  wire req_rise; // request signal rising edge

  // slave layout tables, indexed by bus address
  reg [7:0] len_mem [0:124]; // effective byte length
  reg [11:0] start_mem [0:124]; // first window word
  reg asg_mem [0:124]; // region assigned
  reg scan_busy_reg; // layout being recomputed
  reg [6:0] scan_idx_reg; // slave under scan
  reg [12:0] acc_reg; // words assigned so far
  wire [7:0] scan_words; // words of scanned slave
  wire [12:0] acc_sum; // total after this slave
  wire [7:0] cfg_eff_len; // length actually used

  // two-entry input buffer
  reg [16:0] fifo_mem [0:1]; // beat storage
  reg fifo_wp_reg; // write pointer
  reg fifo_rp_reg; // read pointer
  reg [1:0] fifo_cnt_reg; // entries held
  wire fifo_push; // beat accepted
  wire fifo_pop; // beat consumed
  wire fifo_valid; // head available
  wire drain_ready; // writer can take head
  wire [16:0] head; // head beat

  // window writer
  reg [15:0] win_mem [0:4095]; // input data window
  reg first_reg; // next beat opens a frame
  reg [11:0] wptr_reg; // current window word
  reg [7:0] bcnt_reg; // bytes taken this frame
  reg [7:0] lo_reg; // held low byte
  reg [6:0] fidx_reg; // slave of current frame
  wire [6:0] h_idx; // head slave index
  wire [7:0] h_byte; // head data byte
  wire h_last; // head ends frame
  wire h_ok; // head exchange good
  wire [6:0] cur_idx; // slave for this beat
  wire [11:0] cur_ptr; // word for this beat
  wire [7:0] cur_cnt; // byte number this beat
  wire wr_en; // beat lands in window
  wire [14:0] win_ofs; // host window offset

  assign comm_mode = mode_reg[2];
  assign req_rise = mode_change_req & ~req_d_reg;

  // mode change handling and nonvolatile image
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= ST_PARAM;
      stored_reg <= `SMIM_NV_NONE;
      boot_reg <= 1'b1;
      req_code_reg <= `SMIM_REQ_GUARD;
      outcome_reg <= `SMIM_OUT_RESET;
      req_d_reg <= 1'b0;
      mode_change_done <= 1'b0;
    end
    else
    begin
      req_d_reg <= mode_change_req;
      // host write to the request code
      if (bm_wr && bm_addr == `SMIM_OFS_REQ_CODE)
      begin
        req_code_reg <= bm_wdata;
      end
      // done follows the request level down
      if (!mode_change_req)
      begin
        mode_change_done <= 1'b0;
      end
      if (boot_reg)
      begin
        // start in the mode the image names
        boot_reg <= 1'b0;
        stored_reg <= nv_mode_in;
        if (nv_mode_in == `SMIM_NV_COMM)
        begin
          mode_reg <= ST_COMM;
        end
      end
      else if (req_rise)
      begin
        // one outcome per rising edge
        mode_change_done <= 1'b1;
        outcome_reg <= `SMIM_OUT_OK;
        case (req_code_reg)
          `SMIM_REQ_GUARD:
          begin
            outcome_reg <= `SMIM_OUT_GUARD;
          end
          `SMIM_CODE_PARAM:
          begin
            mode_reg <= ST_PARAM;
          end
          `SMIM_CODE_DIAG:
          begin
            mode_reg <= ST_DIAG;
          end
          `SMIM_CODE_COMM:
          begin
            mode_reg <= ST_COMM;
          end
          `SMIM_CODE_INIT:
          begin
            mode_reg <= ST_INIT;
          end
          `SMIM_CODE_PARAM_NV:
          begin
            mode_reg <= ST_PARAM;
            stored_reg <= `SMIM_NV_PARAM;
          end
          `SMIM_CODE_COMM_NV:
          begin
            mode_reg <= ST_COMM;
            stored_reg <= `SMIM_NV_COMM;
          end
          `SMIM_CODE_ERASE:
          begin
            mode_reg <= ST_PARAM;
            stored_reg <= `SMIM_NV_NONE;
          end
          default:
          begin
            outcome_reg <= `SMIM_OUT_BAD_CODE;
          end
        endcase
      end
    end
  end

  // decode active and stored mode codes
  always @*
  begin
    case (mode_reg)
      ST_PARAM:
        active_code = (stored_reg == `SMIM_NV_PARAM) ?
          `SMIM_CODE_PARAM_NV : `SMIM_CODE_PARAM;
      ST_DIAG:
        active_code = `SMIM_CODE_DIAG;
      ST_COMM:
        active_code = (stored_reg == `SMIM_NV_COMM) ?
          `SMIM_CODE_COMM_NV : `SMIM_CODE_COMM;
      ST_INIT:
        active_code = `SMIM_CODE_INIT;
      default:
        active_code = `SMIM_CODE_PARAM;
    endcase
    case (stored_reg)
      `SMIM_NV_PARAM:
        stored_code = `SMIM_CODE_PARAM_NV;
      `SMIM_NV_COMM:
        stored_code = `SMIM_CODE_COMM_NV;
      default:
        stored_code = `SMIM_CODE_NONE;
    endcase
  end

  // local error, address and test status capture
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err_reg <= `SMIM_ERR_NONE;
      own_addr_reg <= `SMIM_ADDR_UNSET;
      test_reg <= 16'h0000;
      nv_mode_out <= `SMIM_NV_NONE;
    end
    else
    begin
      nv_mode_out <= stored_reg;
      // a new fault wins over a clear in the same cycle
      if (fault_valid && fault_code != `SMIM_ERR_NONE)
      begin
        err_reg <= fault_code;
      end
      else if (diag_clear_request)
      begin
        err_reg <= `SMIM_ERR_NONE;
      end
      // address shown only once parameters exist
      if (params_set && node_addr <= `SMIM_ADDR_MAX)
      begin
        own_addr_reg <= {9'h000, node_addr};
      end
      else
      begin
        own_addr_reg <= `SMIM_ADDR_UNSET;
      end
      test_reg <= test_status;
    end
  end

  // register read port, one cycle latency
  assign win_ofs = bm_addr - `SMIM_OFS_WIN_FIRST;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bm_rdata <= 16'h0000;
      bm_rvalid <= 1'b0;
    end
    else
    begin
      bm_rvalid <= bm_rd;
      if (bm_rd)
      begin
        if (bm_addr >= `SMIM_OFS_WIN_FIRST && bm_addr <= `SMIM_OFS_WIN_LAST)
        begin
          bm_rdata <= win_mem[win_ofs[11:0]];
        end
        else
        begin
          case (bm_addr)
            `SMIM_OFS_ACTIVE_MODE: bm_rdata <= active_code;
            `SMIM_OFS_REQ_CODE: bm_rdata <= req_code_reg;
            `SMIM_OFS_OUTCOME: bm_rdata <= outcome_reg;
            `SMIM_OFS_OWN_ADDR: bm_rdata <= own_addr_reg;
            `SMIM_OFS_TEST_STATE: bm_rdata <= test_reg;
            `SMIM_OFS_STORED_MODE: bm_rdata <= stored_code;
            `SMIM_OFS_LOCAL_ERR: bm_rdata <= err_reg;
            default: bm_rdata <= 16'h0000; // unmapped reads zero
          endcase
        end
      end
    end
  end

  // fixed length slaves override the configured one
  assign cfg_eff_len = cfg_fixed ? cfg_fixed_len : cfg_len;
  // odd lengths round up to a whole word
  assign scan_words = {1'b0, len_mem[scan_idx_reg][7:1]} +
    {7'h00, len_mem[scan_idx_reg][0]};
  assign acc_sum = acc_reg + {5'h00, scan_words};

  // slave lengths and layout recompute
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < `SMIM_SLAVES; i = i + 1)
      begin
        len_mem[i] <= 8'h00;
        start_mem[i] <= 12'h000;
        asg_mem[i] <= 1'b0;
      end
      scan_busy_reg <= 1'b1;
      scan_idx_reg <= 7'h00;
      acc_reg <= 13'h0000;
    end
    else
    begin
      if (cfg_wr && cfg_slave <= `SMIM_LAST_SLAVE &&
          cfg_eff_len <= `SMIM_MAX_LEN)
      begin
        // any change restarts the layout from slave zero
        len_mem[cfg_slave] <= cfg_eff_len;
        scan_busy_reg <= 1'b1;
        scan_idx_reg <= 7'h00;
        acc_reg <= 13'h0000;
      end
      else if (scan_busy_reg)
      begin
        // ascending address gives ascending window position
        start_mem[scan_idx_reg] <= acc_reg[11:0];
        if (len_mem[scan_idx_reg] == 8'h00 || acc_sum > `SMIM_WIN_WORDS)
        begin
          asg_mem[scan_idx_reg] <= 1'b0;
        end
        else
        begin
          asg_mem[scan_idx_reg] <= 1'b1;
          acc_reg <= acc_sum;
        end
        if (scan_idx_reg == `SMIM_LAST_SLAVE)
        begin
          scan_busy_reg <= 1'b0;
        end
        else
        begin
          scan_idx_reg <= scan_idx_reg + 7'h01;
        end
      end
    end
  end

  // two-entry buffer between link and window writer
  assign slv_ready = (fifo_cnt_reg != 2'h2);
  assign fifo_valid = (fifo_cnt_reg != 2'h0);
  assign drain_ready = ~scan_busy_reg; // stall during relayout
  assign fifo_push = slv_valid & slv_ready;
  assign fifo_pop = fifo_valid & drain_ready;
  assign head = fifo_mem[fifo_rp_reg];
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_mem[0] <= 17'h00000;
      fifo_mem[1] <= 17'h00000;
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_mem[fifo_wp_reg] <= {slv_index, slv_byte, slv_last, slv_ok};
        fifo_wp_reg <= ~fifo_wp_reg;
      end
      if (fifo_pop)
      begin
        fifo_rp_reg <= ~fifo_rp_reg;
      end
      // count follows push and pop together
      case ({fifo_push, fifo_pop})
        2'b10: fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
        2'b01: fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
        default: fifo_cnt_reg <= fifo_cnt_reg;
      endcase
    end
  end

  // head fields and per-beat placement
  assign h_idx = head[16:10];
  assign h_byte = head[9:2];
  assign h_last = head[1];
  assign h_ok = head[0];
  assign cur_idx = first_reg ? h_idx : fidx_reg;
  assign cur_ptr = first_reg ? start_mem[h_idx] : wptr_reg;
  assign cur_cnt = first_reg ? 8'h00 : bcnt_reg;
  // failed frames and other modes leave the window alone
  assign wr_en = fifo_pop && comm_mode && h_ok &&
    cur_idx <= `SMIM_LAST_SLAVE && asg_mem[cur_idx] &&
    cur_cnt < len_mem[cur_idx];

  // pack bytes into window words
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_reg <= 1'b1;
      wptr_reg <= 12'h000;
      bcnt_reg <= 8'h00;
      lo_reg <= 8'h00;
      fidx_reg <= 7'h00;
    end
    else if (fifo_pop)
    begin
      first_reg <= h_last;
      fidx_reg <= cur_idx;
      bcnt_reg <= cur_cnt + 8'h01;
      wptr_reg <= cur_ptr;
      if (cur_cnt[0] == 1'b0)
      begin
        // low byte waits for its partner
        lo_reg <= h_byte;
      end
      else
      begin
        wptr_reg <= cur_ptr + 12'h001;
      end
    end
  end

  // window storage writes
  always @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      if (cur_cnt[0] == 1'b1)
      begin
        win_mem[cur_ptr] <= {h_byte, lo_reg};
      end
      else if (h_last || cur_cnt + 8'h01 == len_mem[cur_idx])
      begin
        // odd tail carries a zero upper byte
        win_mem[cur_ptr] <= {8'h00, h_byte};
      end
    end
  end

endmodule

// File: bench/smim_checker_assertions.sv
// port checker for the station mode block
// assumes one ref_clk domain, bound onto smim_station_regs
`timescale 1ns/1ps
module smim_checker (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // buffer memory side
  input wire bm_rd,
  input wire [15:0] bm_rdata,
  input wire bm_rvalid,
  // mode request side
  input wire mode_change_req,
  input wire mode_change_done,
  input wire [1:0] nv_mode_out,
  input wire comm_mode,
  // stream side
  input wire slv_valid,
  input wire slv_ready
);
  // cycles since reset release, saturating
  reg [2:0] up_reg;
  wire settled;
  // count up after release so $past never looks into reset
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  assign settled = (up_reg == 3'h7);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rd_ans; bm_rd |=> bm_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_quiet; settled && !bm_rd |=> !bm_rvalid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
  property p_rdata_hold; settled && !bm_rvalid |-> $stable(bm_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_done_rise; settled && $rose(mode_change_req) |=> mode_change_done; endproperty
  a_done_rise: assert property (p_done_rise) else $error("no done");
  property p_done_fall; !mode_change_req |=> !mode_change_done; endproperty
  a_done_fall: assert property (p_done_fall) else $error("done stuck");
  property p_done_hold; mode_change_req && mode_change_done |=> mode_change_done; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  property p_comm_chg;
    settled && $changed(comm_mode) |-> $past(mode_change_req) && !$past(mode_change_req, 2);
  endproperty
  a_comm_chg: assert property (p_comm_chg) else $error("mode moved alone");
  property p_nv_chg;
    settled && $changed(nv_mode_out) |-> $past(mode_change_req, 2) && !$past(mode_change_req, 3);
  endproperty
  a_nv_chg: assert property (p_nv_chg) else $error("store moved alone");
  property p_ready_fall; settled && $fell(slv_ready) |-> $past(slv_valid); endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready fell idle");
  // main scenarios reached
  c_req: cover property (settled && $rose(mode_change_req));
  c_stall: cover property (slv_valid && !slv_ready);
  c_comm: cover property ($rose(comm_mode));
endmodule
bind smim_station_regs smim_checker u_smim_checker (.ref_clk(ref_clk), .arst_n(arst_n),
  .bm_rd(bm_rd), .bm_rdata(bm_rdata), .bm_rvalid(bm_rvalid),
  .mode_change_req(mode_change_req), .mode_change_done(mode_change_done),
  .nv_mode_out(nv_mode_out), .comm_mode(comm_mode), .slv_valid(slv_valid),
  .slv_ready(slv_ready));

// File: bench/smim_slave_src.sv
// remote slave input source feeding the byte stream
// assumes beats taken on rising ref_clk with valid and ready high
`timescale 1ns/1ps
module smim_slave_src (
  // clock
  input wire ref_clk,
  // stream to the block
  output reg slv_valid,
  output reg [6:0] slv_index,
  output reg [7:0] slv_byte,
  output reg slv_last,
  output reg slv_ok,
  input wire slv_ready,
  // status to the bench
  output reg timed_out,
  output reg saw_stall
);
  initial
  begin
    slv_valid = 1'b0;
    slv_index = 7'h00;
    slv_byte = 8'h00;
    slv_last = 1'b0;
    slv_ok = 1'b0;
    timed_out = 1'b0;
    saw_stall = 1'b0;
  end
  // one frame, low byte first, ok held for all beats, random gaps
  task send(input [6:0] idx, input integer len, input [31:0] dat, input ok);
    integer k;
    integer w;
    begin
      @(posedge ref_clk);
      for (k = 0; k < len; k = k + 1)
      begin
        if ($urandom % 3 == 0)
        begin
          slv_valid <= 1'b0;
          slv_byte <= ~slv_byte;
          @(posedge ref_clk);
        end
        slv_valid <= 1'b1;
        slv_index <= idx;
        slv_byte <= dat[8*k +: 8];
        slv_last <= (k == len - 1);
        slv_ok <= ok;
        w = 0;
        // ready settles before the falling edge
        @(negedge ref_clk);
        while (!slv_ready && w < 500)
        begin
          saw_stall = 1'b1;
          w = w + 1;
          @(negedge ref_clk);
        end
        if (w == 500)
          timed_out = 1'b1;
        @(posedge ref_clk);
      end
      // released data lines toggle, never hold the last byte
      slv_valid <= 1'b0;
      slv_byte <= ~slv_byte;
    end
  endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the station mode and input map block
// assumes smim_defines.vh on the include path
`timescale 1ns/1ps
`include "smim_defines.vh"
module tb_top;
  reg ref_clk;
  reg arst_n;
  reg [14:0] bm_addr;
  reg bm_rd;
  reg bm_wr;
  reg [15:0] bm_wdata;
  reg mode_change_req;
  reg diag_clear_request;
  reg [1:0] nv_mode_in;
  reg fault_valid;
  reg [15:0] fault_code;
  reg [6:0] node_addr;
  reg params_set;
  reg [15:0] test_status;
  reg cfg_wr;
  reg [6:0] cfg_slave;
  reg [7:0] cfg_len;
  reg cfg_fixed;
  reg [7:0] cfg_fixed_len;
  wire [15:0] bm_rdata;
  wire bm_rvalid;
  wire mode_change_done;
  wire [1:0] nv_mode_out;
  wire slv_ready;
  wire comm_mode;
  wire slv_valid;
  wire [6:0] slv_index;
  wire [7:0] slv_byte;
  wire slv_last;
  wire slv_ok;
  wire timed_out;
  wire saw_stall;
  integer fail_count;
  integer num_checks;
  integer i;
  reg [15:0] v;
  reg [15:0] cur;
  reg [15:0] st;
  reg [31:0] d0;
  reg [31:0] d1;
  reg [127:0] codes;
  smim_station_regs u_smim_station_regs (.ref_clk(ref_clk), .arst_n(arst_n),
    .bm_addr(bm_addr), .bm_rd(bm_rd), .bm_wr(bm_wr), .bm_wdata(bm_wdata),
    .bm_rdata(bm_rdata), .bm_rvalid(bm_rvalid), .mode_change_req(mode_change_req),
    .diag_clear_request(diag_clear_request), .mode_change_done(mode_change_done),
    .nv_mode_in(nv_mode_in), .nv_mode_out(nv_mode_out), .fault_valid(fault_valid),
    .fault_code(fault_code), .node_addr(node_addr), .params_set(params_set),
    .test_status(test_status), .cfg_wr(cfg_wr), .cfg_slave(cfg_slave), .cfg_len(cfg_len),
    .cfg_fixed(cfg_fixed), .cfg_fixed_len(cfg_fixed_len), .slv_valid(slv_valid),
    .slv_ready(slv_ready), .slv_index(slv_index), .slv_byte(slv_byte),
    .slv_last(slv_last), .slv_ok(slv_ok), .comm_mode(comm_mode));
  smim_slave_src u_smim_slave_src (.ref_clk(ref_clk), .slv_valid(slv_valid),
    .slv_index(slv_index), .slv_byte(slv_byte), .slv_last(slv_last), .slv_ok(slv_ok),
    .slv_ready(slv_ready), .timed_out(timed_out), .saw_stall(saw_stall));
  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // compare and count
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // verdict and stop
  task end_sim;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // one buffer memory read, answer one cycle later
  task rd(input [14:0] a);
    begin
      @(posedge ref_clk);
      bm_rd <= 1'b1;
      bm_addr <= a;
      @(posedge ref_clk);
      bm_rd <= 1'b0;
      #1 chk("rvalid", {15'h0, bm_rvalid}, 16'h0001);
      v = bm_rdata;
    end
  endtask
  // one buffer memory write
  task wr(input [14:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      bm_wr <= 1'b1;
      bm_addr <= a;
      bm_wdata <= d;
      @(posedge ref_clk);
      bm_wr <= 1'b0;
    end
  endtask
  // raise the request for four cycles, then drop it
  task pulse;
    begin
      @(posedge ref_clk);
      mode_change_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk("done", {15'h0, mode_change_done}, 16'h0001);
      @(posedge ref_clk);
      mode_change_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  // request a mode, track expected mode and store, check outcome
  task set_mode(input [15:0] c);
    reg good;
    begin
      good = (c == 16'h0001) || (c == 16'h0002) || (c == 16'h0003) || (c == 16'h0009) ||
        (c == 16'h0101) || (c == 16'h0103) || (c == 16'hFFFF);
      wr(`SMIM_OFS_REQ_CODE, c);
      pulse;
      if (good)
      begin
        cur = (c == 16'hFFFF) ? 16'h0001 : {8'h00, c[7:0]};
        if (c[8])
          st = c;
      end
      rd(`SMIM_OFS_OUTCOME);
      chk("outcome ok", {15'h0, v == 16'hA300}, {15'h0, good});
    end
  endtask
  // expected active code
  function [15:0] exp_act(input [15:0] m, input [15:0] s);
    exp_act = (m == 16'h0001 && s == 16'h0101) ? s : (m == 16'h0003 && s == 16'h0103) ? s : m;
  endfunction
  // one slave configuration write
  task cfg(input [6:0] s, input [7:0] l, input f, input [7:0] fl);
    begin
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_slave <= s;
      cfg_len <= l;
      cfg_fixed <= f;
      cfg_fixed_len <= fl;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
    end
  endtask
  // main sequence
  initial
  begin
    {bm_addr, bm_rd, bm_wr, bm_wdata, mode_change_req, diag_clear_request} = 0;
    {nv_mode_in, fault_valid, fault_code, node_addr, params_set, test_status} = 0;
    {cfg_wr, cfg_slave, cfg_len, cfg_fixed, cfg_fixed_len} = 0;
    fail_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    cur = 16'h0001;
    st = 16'hFFFF;
    d0 = $urandom(20747);
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`SMIM_OFS_REQ_CODE);
    chk("req reset", v, 16'hFFFE);
    rd(`SMIM_OFS_LOCAL_ERR);
    chk("err idle", v, 16'h0000);
    rd(15'h0100);
    chk("unmapped", v, 16'h0000);
    wr(`SMIM_OFS_ACTIVE_MODE, 16'h0003);
    pulse;
    rd(`SMIM_OFS_OUTCOME);
    chk("guard", v, 16'hE300);
    rd(`SMIM_OFS_ACTIVE_MODE);
    chk("guard mode", v, 16'h0001);
    // every code including 0101, plus a random unknown one in place of 1000
    codes = {16'h0002, 16'h0009, 16'h0103, 16'h0001, 16'h0003, 16'h0101, 16'h1000, 16'hFFFF};
    d0 = $urandom;
    codes[31:16] = {4'h1, d0[11:0]};
    for (i = 7; i >= -1; i = i - 1)
    begin
      if (i >= 0)
        set_mode(codes[16*i +: 16]);
      rd(`SMIM_OFS_ACTIVE_MODE);
      chk("active", v, exp_act(cur, st));
      rd(`SMIM_OFS_STORED_MODE);
      chk("stored", v, st);
      chk("nv out", {14'h0, nv_mode_out},
        (st == 16'h0101) ? 16'h0001 : (st == 16'h0103) ? 16'h0002 : 16'h0000);
      chk("comm", {15'h0, comm_mode}, {15'h0, cur == 16'h0003});
    end
    // sticky local error
    @(posedge ref_clk);
    fault_valid <= 1'b1;
    d0 = $urandom | 32'h1;
    fault_code <= d0[15:0];
    @(posedge ref_clk);
    fault_valid <= 1'b0;
    fault_code <= 16'h0000;
    repeat (3) rd(`SMIM_OFS_LOCAL_ERR);
    chk("err held", v, d0[15:0]);
    @(posedge ref_clk);
    diag_clear_request <= 1'b1;
    @(posedge ref_clk);
    diag_clear_request <= 1'b0;
    rd(`SMIM_OFS_LOCAL_ERR);
    chk("err clr", v, 16'h0000);
    // own address unset, limits and random; test state
    rd(`SMIM_OFS_OWN_ADDR);
    chk("addr unset", v, 16'hFFFF);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge ref_clk);
      d1 = $urandom;
      node_addr <= (i == 0) ? 7'h7D : (i == 1) ? 7'h00 : d1[22:16] % 7'd126;
      params_set <= 1'b1;
      test_status <= d1[15:0];
      repeat (2) @(posedge ref_clk);
      rd(`SMIM_OFS_OWN_ADDR);
      chk("addr", v, {9'h000, node_addr});
      rd(`SMIM_OFS_TEST_STATE);
      chk("test", v, test_status);
    end
    // two slaves configured out of order
    cfg(7'd10, 8'h03, 1'b0, 8'h00);
    cfg(7'd3, 8'h02, 1'b0, 8'h00);
    repeat (130) @(posedge ref_clk);
    set_mode(16'h0003);
    d0 = $urandom;
    d1 = $urandom;
    u_smim_slave_src.send(7'd3, 2, d0, 1'b1);
    u_smim_slave_src.send(7'd10, 3, d1, 1'b1);
    repeat (6) @(posedge ref_clk);
    rd(15'h1800);
    chk("win0", v, d0[15:0]);
    rd(15'h1801);
    chk("win1", v, d1[15:0]);
    rd(15'h1802);
    chk("win2", v, {8'h00, d1[23:16]});
    // failed exchange, then traffic outside comm mode
    u_smim_slave_src.send(7'd3, 2, ~d0, 1'b0);
    set_mode(16'h0001);
    u_smim_slave_src.send(7'd3, 2, ~d0, 1'b1);
    repeat (6) @(posedge ref_clk);
    rd(15'h1800);
    chk("win hold", v, d0[15:0]);
    // insert fixed-length slave 5, frames queue during the layout scan
    set_mode(16'h0003);
    cfg(7'd5, 8'd200, 1'b1, 8'h02);
    u_smim_slave_src.send(7'd10, 3, ~d1, 1'b1);
    u_smim_slave_src.send(7'd5, 2, d1, 1'b1);
    // over-long config refused, bytes past the length dropped
    cfg(7'd3, 8'd245, 1'b0, 8'h00);
    u_smim_slave_src.send(7'd3, 3, ~d0, 1'b1);
    repeat (6) @(posedge ref_clk);
    rd(15'h1800);
    chk("len cap", v, ~d0[15:0]);
    rd(15'h1801);
    chk("fixed", v, d1[15:0]);
    rd(15'h1802);
    chk("shift", v, ~d1[15:0]);
    rd(15'h1803);
    chk("shift odd", v, {8'h00, ~d1[23:16]});
    // mid-run reset, image names communication mode
    @(posedge ref_clk);
    arst_n <= 1'b0;
    nv_mode_in <= 2'h2;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`SMIM_OFS_ACTIVE_MODE);
    chk("boot active", v, 16'h0103);
    rd(`SMIM_OFS_STORED_MODE);
    chk("boot stored", v, 16'h0103);
    chk("boot nv", {14'h0, nv_mode_out}, 16'h0002);
    chk("stall", {15'h0, saw_stall}, 16'h0001);
    chk("timeout", {15'h0, timed_out}, 16'h0000);
    end_sim;
  end
endmodule
